// file: shared/bit_skip_cfg.svh
// Constants for the bit test, toggle, skip and overflow branch decoder
`ifndef BIT_SKIP_CFG_SVH
`define BIT_SKIP_CFG_SVH
`define OP_SKIP_CLEAR      4'hB
`define OP_SKIP_SET        4'hA
`define OP_BIT_INVERT      4'h7
`define OP_BRANCH_GROUP    4'hE
`define OP_BRANCH_OV_SUB   4'h4
`define OP_SECOND_WORD     4'hF
`define OP_PREFIX_MSB      15
`define OP_PREFIX_LSB      12
`define OP_SUB_MSB         11
`define OP_SUB_LSB         8
`define BIT_IDX_MSB        11
`define BIT_IDX_LSB        9
`define BANK_FLAG_POS      8
`define ADDR_MSB           7
`define ADDR_LSB           0
`define INDEXED_MAX_ADDR   8'h5F
`define ACCESS_SPLIT_ADDR  8'h60
`define ACCESS_HIGH_BANK   6'h3F
`define QUARTER_LAST       2'h3
`define QUARTER_DECODE     2'h0
`define QUARTER_PROCESS    2'h2
`define PC_STEP            21'h000002
`endif

// file: shared/bit_skip_pkg.sv
// Types for the bit test, toggle, skip and overflow branch decoder
package bit_skip_pkg;
  typedef logic [15:0] insn_t;
  typedef logic [20:0] pc_t;
  typedef logic [13:0] daddr_t;
  typedef logic [7:0]  byte_t;
  typedef enum logic [3:0] {
    ST_EXEC   = 4'h1,
    ST_NOP1   = 4'h2,
    ST_NOP2   = 4'h4,
    ST_BRANCH = 4'h8
  } cyc_e;
endpackage

// file: rtl/bit_skip_decode.sv
// Decode and execute of bit test skip, bit invert and branch on overflow
// Operation
// - Opcode 1011 skips the next instruction when the tested bit is zero.
// - Opcode 1010 skips the next instruction when the tested bit is one.
// - Skipping a one-word instruction discards the prefetched word and runs one no-operation cycle.
// - Skipping a two-word instruction costs three cycles with two no-operation cycles.
// - Bank flag zero resolves the address within the Access Bank.
// - Bank flag one combines the bank select register with the address.
// - Flag zero, extended set, address up to 95 uses indexed literal offset.
// - Opcode 0111 inverts one bit, writes it back, other bits kept.
// - Branch on overflow changes the program counter only with overflow set.
// - Taken branch target is instruction address plus two plus twice offset.
// - Branch opcode group 1110 holds a signed 8-bit offset, doubled.
// - A lone second word of a two-word instruction acts as no-operation.
// - Each instruction cycle spans four clock periods in four quarters.
`timescale 1ns/1ps
`include "bit_skip_cfg.svh"
module bit_skip_decode (
  input  wire logic                ref_clk,       // Core clock, 40 MHz
  input  wire logic                reset,         // Synchronous reset, active high
  input  wire bit_skip_pkg::insn_t insnWord,      // Instruction being executed
  input  wire bit_skip_pkg::pc_t   insnAddr,      // Address of that instruction
  input  wire bit_skip_pkg::insn_t nextWord,      // Prefetched following word
  input  wire logic                nextTwoWord,   // Prefetched word starts a 2-word op
  input  wire logic [5:0]          bankSelectReg, // Bank select register
  input  wire logic                extendedEn,    // Extended instruction set enabled
  input  wire bit_skip_pkg::daddr_t fsrBase,      // Base pointer for indexed mode
  input  wire bit_skip_pkg::byte_t readData,      // Data read at Q2
  input  wire logic                overflowFlag,  // Overflow status flag
  output logic [1:0]               quarter,       // Current quarter phase
  output logic                     cycleStart,    // Pulse at start of each cycle
  output bit_skip_pkg::daddr_t     dataAddr,      // Resolved data address
  output logic                     writeEn,       // Write strobe at Q4
  output bit_skip_pkg::byte_t      writeData,     // Data written back
  output logic                     pcLoad,        // Load program counter at Q4
  output bit_skip_pkg::pc_t        pcTarget,      // New program counter
  output logic                     flushFetch,    // Discard prefetched word
  output logic                     execNop,       // Cycle runs as no-operation
  output logic                     statusWe       // Status flag write, always zero here
);
  import bit_skip_pkg::*;

  logic [1:0]  quarterReg, quarterNext;
  cyc_e        stateReg, stateNext;
  daddr_t      addrReg, addrNext;
  logic        weReg, weNext, pcLdReg, pcLdNext, flushReg, flushNext, nopReg, nopNext;
  byte_t       wdReg, wdNext;
  pc_t         pcReg, pcNext;
  logic        startReg, startNext;
  logic        statusReg, statusNext;

  logic [3:0]  prefix;
  logic [2:0]  bitIdx;
  logic        bankFlag;
  byte_t       fAddr;
  logic        bitVal, isClr, isSet, isInv, isBov, isSecond, skipHit;
  daddr_t      resolved;
  pc_t         offs;

  assign prefix   = insnWord[`OP_PREFIX_MSB:`OP_PREFIX_LSB];
  assign bitIdx   = insnWord[`BIT_IDX_MSB:`BIT_IDX_LSB];
  assign bankFlag = insnWord[`BANK_FLAG_POS];
  assign fAddr    = insnWord[`ADDR_MSB:`ADDR_LSB];
  assign bitVal   = readData[bitIdx];
  assign isClr    = (prefix == `OP_SKIP_CLEAR);
  assign isSet    = (prefix == `OP_SKIP_SET);
  assign isInv    = (prefix == `OP_BIT_INVERT);
  assign isBov    = (prefix == `OP_BRANCH_GROUP)
                    && (insnWord[`OP_SUB_MSB:`OP_SUB_LSB] == `OP_BRANCH_OV_SUB);
  assign isSecond = (prefix == `OP_SECOND_WORD);
  assign skipHit  = (isClr && !bitVal) || (isSet && bitVal);
  assign offs     = {{12{insnWord[7]}}, insnWord[7:0], 1'b0};

  // Data address resolution
  always_comb begin
    if (bankFlag) begin
      resolved = {bankSelectReg, fAddr};
    end else if (extendedEn && (fAddr <= `INDEXED_MAX_ADDR)) begin
      resolved = fsrBase + {6'h00, fAddr};
    end else if (fAddr < `ACCESS_SPLIT_ADDR) begin
      resolved = {6'h00, fAddr};
    end else begin
      resolved = {`ACCESS_HIGH_BANK, fAddr};
    end
  end

  // Quarter phase sequencing
  always_comb begin
    quarterNext = quarterReg + 2'h1;
    startNext   = (quarterReg == `QUARTER_LAST);
  end

  // Instruction cycle control
  always_comb begin
    stateNext = stateReg;
    addrNext  = addrReg;
    weNext    = 1'b0;
    wdNext    = wdReg;
    pcLdNext  = 1'b0;
    pcNext    = pcReg;
    flushNext = 1'b0;
    nopNext    = nopReg;
    statusNext = 1'b0;
    if (quarterReg == `QUARTER_LAST) begin
      case (stateReg)
        ST_EXEC: begin
          if (skipHit) begin
            flushNext = 1'b1;
            stateNext = nextTwoWord ? ST_NOP2 : ST_NOP1;
          end else if (isBov && overflowFlag) begin
            flushNext = 1'b1;
            stateNext = ST_BRANCH;
          end
        end
        ST_NOP2: begin
          flushNext = 1'b1;
          stateNext = ST_NOP1;
        end
        ST_NOP1, ST_BRANCH: begin
          stateNext = ST_EXEC;
        end
        default: stateNext = ST_EXEC;
      endcase
    end else if (quarterReg == `QUARTER_DECODE) begin
      // Taken at decode, so the flag spans one full cycle trailing by one clock
      nopNext = (stateReg != ST_EXEC) || isSecond;
      if (stateReg == ST_EXEC) begin
        addrNext = resolved;
      end
    end else if (quarterReg == `QUARTER_PROCESS && stateReg == ST_EXEC && !isSecond) begin
      if (isInv) begin
        wdNext = readData ^ (byte_t'(1) << bitIdx);
        weNext = 1'b1;
      end
      if (isBov && overflowFlag) begin
        pcNext   = insnAddr + `PC_STEP + offs;
        pcLdNext = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      quarterReg <= 2'h0;
      startReg   <= 1'b0;
      stateReg   <= ST_EXEC;
      addrReg    <= 14'h0000;
      weReg      <= 1'b0;
      wdReg      <= 8'h00;
      pcLdReg    <= 1'b0;
      pcReg      <= 21'h000000;
      flushReg   <= 1'b0;
      nopReg     <= 1'b0;
      statusReg  <= 1'b0;
    end else begin
      quarterReg <= quarterNext;
      startReg   <= startNext;
      stateReg   <= stateNext;
      addrReg    <= addrNext;
      weReg      <= weNext;
      wdReg      <= wdNext;
      pcLdReg    <= pcLdNext;
      pcReg      <= pcNext;
      flushReg   <= flushNext;
      nopReg     <= nopNext;
      statusReg  <= statusNext;
    end
  end

  assign quarter    = quarterReg;
  assign cycleStart = startReg;
  assign dataAddr   = addrReg;
  assign writeEn    = weReg;
  assign writeData  = wdReg;
  assign pcLoad     = pcLdReg;
  assign pcTarget   = pcReg;
  assign flushFetch = flushReg;
  assign execNop    = nopReg;
  assign statusWe   = statusReg;

  chk_untaken_one_cycle: assert property (@(posedge ref_clk) disable iff (reset)
    (quarterReg == `QUARTER_LAST && stateReg == ST_EXEC && isBov && !overflowFlag
     && !skipHit) |=> stateReg == ST_EXEC) else $error("untaken branch not one cycle");
  chk_skip_flush: assert property (@(posedge ref_clk) disable iff (reset)
    (quarterReg == `QUARTER_LAST && stateReg == ST_EXEC && skipHit) |=> flushFetch)
    else $error("skip did not flush");
  chk_two_word_skip: assert property (@(posedge ref_clk) disable iff (reset)
    (quarterReg == `QUARTER_LAST && stateReg == ST_EXEC && skipHit && nextTwoWord)
    |=> ##4 stateReg == ST_NOP1) else $error("two-word skip not three cycles");
  chk_quarter_wrap: assert property (@(posedge ref_clk) disable iff (reset)
    cycleStart |-> quarter == 2'h0 ##1 !cycleStart [*3] ##1 cycleStart)
    else $error("cycle not four quarters");
  chk_branch_load: assert property (@(posedge ref_clk) disable iff (reset)
    pcLoad |-> $past(overflowFlag)) else $error("branch without overflow");
  chk_no_status: assert property (@(posedge ref_clk) disable iff (reset)
    !statusWe) else $error("status written");
  chk_invert_one_bit: assert property (@(posedge ref_clk) disable iff (reset)
    writeEn |-> $countones(writeData ^ $past(readData)) == 1) else $error("invert wrong");
  chk_bank_addr: assert property (@(posedge ref_clk) disable iff (reset)
    (quarterReg == 2'h0 && stateReg == ST_EXEC && bankFlag)
    |=> dataAddr == {$past(bankSelectReg), $past(fAddr)}) else $error("bank address wrong");

  // Steps of a single skip and of a lone second word
  sequence s_skip_single;
    quarterReg == `QUARTER_LAST && stateReg == ST_EXEC && skipHit && !nextTwoWord;
  endsequence
  sequence s_one_nop_cycle;
    (stateReg == ST_NOP1) [*4] ##1 stateReg == ST_EXEC;
  endsequence
  sequence s_lone_word;
    quarterReg == `QUARTER_DECODE && stateReg == ST_EXEC && isSecond;
  endsequence

  chk_single_skip: assert property (@(posedge ref_clk) disable iff (reset)
    s_skip_single |=> s_one_nop_cycle) else $error("skip not two cycles");
  chk_lone_word_nop: assert property (@(posedge ref_clk) disable iff (reset)
    s_lone_word |=> (execNop && !writeEn && !pcLoad) [*4])
    else $error("lone second word not a no-operation");
  chk_branch_target: assert property (@(posedge ref_clk) disable iff (reset)
    pcLoad |-> pcTarget == pc_t'($past(insnAddr) + `PC_STEP + $past(offs)))
    else $error("branch target wrong");
  chk_indexed_addr: assert property (@(posedge ref_clk) disable iff (reset)
    (quarterReg == `QUARTER_DECODE && stateReg == ST_EXEC && !bankFlag && extendedEn
     && fAddr <= `INDEXED_MAX_ADDR)
    |=> dataAddr == daddr_t'($past(fsrBase) + {6'h00, $past(fAddr)}))
    else $error("indexed address wrong");
  chk_access_addr: assert property (@(posedge ref_clk) disable iff (reset)
    (quarterReg == `QUARTER_DECODE && stateReg == ST_EXEC && !bankFlag
     && !(extendedEn && fAddr <= `INDEXED_MAX_ADDR))
    |=> dataAddr == {(($past(fAddr) < `ACCESS_SPLIT_ADDR) ? 6'h00 : `ACCESS_HIGH_BANK),
                     $past(fAddr)}) else $error("access bank address wrong");
endmodule // bit_skip_decode

// file: sim/bit_skip_decode_test.sv
// Self-checking testbench for the bit test, skip, invert and branch decoder
`timescale 1ns/1ps
`include "bit_skip_cfg.svh"
module bit_skip_decode_test;
  import bit_skip_pkg::*;
  logic       ref_clk, reset, nextTwoWord, extendedEn, overflowFlag;
  insn_t      insnWord, nextWord;
  pc_t        insnAddr, pcTarget, capPc;
  logic [5:0] bankSelectReg;
  daddr_t     fsrBase, dataAddr, capAddr;
  byte_t      readData, writeData, capWd;
  logic [1:0] quarter;
  logic       cycleStart, writeEn, pcLoad, flushFetch, execNop, statusWe;
  int         errors, num_checks, nWe, nPc, nFl, nNop, nSt;

  bit_skip_decode i_bit_skip_decode (.ref_clk, .reset, .insnWord, .insnAddr, .nextWord,
    .nextTwoWord, .bankSelectReg, .extendedEn, .fsrBase, .readData, .overflowFlag, .quarter,
    .cycleStart, .dataAddr, .writeEn, .writeData, .pcLoad, .pcTarget, .flushFetch, .execNop,
    .statusWe);

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  task automatic check(string name, logic [20:0] seen, logic [20:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s expected %0h seen %0h", name, exp, seen);
    end
  endtask

  // Presents one instruction at quarter 0, then a plain invert word as filler
  task automatic run(insn_t w, byte_t rd, logic ov, logic two);
    for (int i = 0; i < 8 && quarter !== 2'h0; i++) @(negedge ref_clk);
    insnWord = w;
    readData = rd;
    overflowFlag = ov;
    nextTwoWord = two;
    {nWe, nPc, nFl, nNop, nSt} = '0;
    for (int i = 0; i < 12; i++) begin
      @(negedge ref_clk);
      if (i < 4 && writeEn === 1'b1) nWe++;
      if (i < 4 && writeEn === 1'b1) capWd = writeData;
      if (pcLoad === 1'b1) capPc = pcTarget;
      nPc += int'(pcLoad === 1'b1);
      nFl += int'(flushFetch === 1'b1);
      nNop += int'(execNop === 1'b1);
      nSt += int'(statusWe !== 1'b0);
      if (i == 2) capAddr = dataAddr;
      if (i == 3) insnWord = {`OP_BIT_INVERT, 12'h000};
    end
    check("statusWe", nSt, 0);
  endtask

  task automatic t_phase;
    logic [1:0] q;
    repeat (16) @(negedge ref_clk);
    reset = 1'b0;
    @(negedge ref_clk);
    q = quarter;
    for (int i = 1; i < 9; i++) begin
      @(negedge ref_clk);
      check("quarter", quarter, 2'(q + i));
      check("cycleStart", cycleStart, quarter === 2'h0);
    end
    $display("phase test done");
  endtask

  task automatic t_skip;
    byte_t m;
    logic  skip;
    for (int k = 0; k < 8; k++) begin
      m = 8'h01 << k;
      skip = k[2] ? !k[0] : k[0];
      bankSelectReg = 6'h20 | 6'(k);
      run({k[2] ? `OP_SKIP_CLEAR : `OP_SKIP_SET, 3'(k), 1'b1, 8'hA0 | 8'(k)},
          k[0] ? m : ~m, 1'b0, k[1]);
      check("skipAddr", capAddr, {bankSelectReg, 8'hA0 | 8'(k)});
      check("skipFlush", nFl, skip ? (k[1] ? 2 : 1) : 0);
      check("skipNop", nNop, skip ? (k[1] ? 8 : 4) : 0);
      check("skipWrite", nWe + nPc, 0);
    end
    $display("skip test done");
  endtask

  task automatic t_invert;
    byte_t  fa [5] = '{8'h10, 8'h60, 8'h5F, 8'h60, 8'h5F};
    logic   ex [5] = '{1'h0, 1'h0, 1'h1, 1'h1, 1'h0};
    daddr_t ea [5] = '{14'h0010, 14'h3F60, 14'h0182, 14'h3F60, 14'h005F};
    fsrBase = 14'h0123;
    for (int i = 0; i < 5; i++) begin
      extendedEn = ex[i];
      run({`OP_BIT_INVERT, 3'(i + 2), 1'b0, fa[i]}, 8'h75, 1'b0, 1'b0);
      check("invAddr", capAddr, ea[i]);
      check("invData", capWd, 8'h75 ^ (8'h01 << (i + 2)));
      check("invCount", nWe * 16 + nFl + nNop + nPc, 16);
    end
    extendedEn = 1'b0;
    $display("invert test done");
  endtask

  task automatic t_branch;
    byte_t n [5] = '{8'h80, 8'h7F, 8'h00, 8'hFE, 8'h7F};
    pc_t   exp;
    insnAddr = 21'h001000;
    for (int i = 0; i < 5; i++) begin
      exp = insnAddr + 21'h000002 + {{12{n[i][7]}}, n[i], 1'b0};
      run({`OP_BRANCH_GROUP, `OP_BRANCH_OV_SUB, n[i]}, 8'h00, i < 4, 1'b0);
      check("brLoad", nPc, i < 4);
      if (i < 4) check("brTarget", capPc, exp);
      check("brCycles", nNop + nFl, i < 4 ? 5 : 0);
    end
    $display("branch test done");
  endtask

  task automatic t_second;
    run(16'hF0A5, 8'hFF, 1'b1, 1'b0);
    check("loneNop", nNop, 4);
    check("loneActs", nWe + nPc + nFl, 0);
    $display("second word test done");
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    repeat (4000) @(posedge ref_clk);
    errors++;
    finish_test;
  end

  initial begin
    {reset, nextTwoWord, extendedEn, overflowFlag} = 4'h8;
    {insnWord, nextWord, readData} = '0;
    {insnAddr, bankSelectReg, fsrBase} = '0;
    t_phase;
    t_skip;
    t_invert;
    t_branch;
    t_second;
    finish_test;
  end
endmodule // bit_skip_decode_test
